// ---- core/see_pkg.sv ----
// constants shared by both ends of the serial eeprom link
// assumes spi mode 0 framing and a 200 MHz system clock at each end
package see_pkg;
    // ==========================================================
    // opcodes
    localparam logic [7:0] OP_STATUS_WR = 8'h01;
    localparam logic [7:0] OP_WRITE     = 8'h02;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_RDSR      = 8'h05;
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    // ==========================================================
    // geometry and framing
    localparam int         ADDR_W     = 13;
    localparam int         IDX_W      = 5;
    localparam int         PAGE_BYTES = 32;
    localparam int         CNT_W      = 6;
    localparam logic [5:0] CNT_SAT    = 6'h3F;
    localparam logic [5:0] ONE_BYTE   = 6'h01;
    localparam logic [5:0] STW_BYTES  = 6'h02;
    localparam logic [5:0] HDR_BYTES  = 6'h03;
    localparam logic [5:0] MIN_WRITE  = 6'h04;
    localparam logic [2:0] LAST_BIT   = 3'h7;
    // ==========================================================
    // status bits and protection
    localparam int ST_BUSY = 0;
    localparam int ST_WEL  = 1;
    localparam int ST_PROT_LO = 2;
    localparam int ST_PROT_HI = 3;
    localparam int ST_SRWP = 7;
    localparam logic [1:0]  BP_QUARTER = 2'h1;
    localparam logic [1:0]  BP_HALF    = 2'h2;
    localparam logic [1:0]  BP_ALL     = 2'h3;
    localparam logic [12:0] PROT_Q_LO  = 13'h1800;
    localparam logic [12:0] PROT_H_LO  = 13'h1000;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS  = 10000000;
    localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int PWRUP_TIME_NS = 10000;
    localparam int PWRUP_CYCLES  =
        (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SCK_HALF_NS   = 100;
    localparam int SCK_HALF      =
        (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ---- core/see_spi_if.sv ----
// link between the eeprom end and the host end
// assumes the bench resolves the output line from miso_oe
`timescale 1ns/10ps
interface see_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic hold_n;
    logic wp_n;
    logic miso;
    logic miso_oe;

    modport dev  (input cs_n, sck, mosi, hold_n, wp_n,
                  output miso, miso_oe);
    modport host (output cs_n, sck, mosi, hold_n, wp_n,
                  input miso, miso_oe);
endinterface

// ---- core/see_dev.sv ----
// eeprom end: serial front end on sck, program engine on mclk
// assumes the host keeps cs_n high for some mclk cycles between frames
`timescale 1ns/10ps
module see_dev
    import see_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES
) (
    see_spi_if.dev               spi,
    input  wire logic            mclk,
    input  wire logic            nrst,
    input  wire logic [12:0]     rd_addr,
    output logic      [7:0]      rd_data,
    output logic                 busy,
    output logic                 wel
);
    // ==========================================================
    // link side, clocked by sck, restarted on the first sck after deselect
    logic [2:0]        bit_r;
    logic [CNT_W-1:0]  byte_r;
    logic [7:0]        sh_r;
    logic [7:0]        op_r;
    logic [7:0]        ahi_r;
    logic [7:0]        alo_r;
    logic [IDX_W-1:0]  idx_r;
    logic [PAGE_BYTES-1:0] mask_r;
    logic [7:0]        pbuf [PAGE_BYTES];
    logic [7:0]        so_r;
    logic [7:0]        st_s1;
    logic [7:0]        st_s2;
    logic              bsy_s1;
    logic              bsy_s2;
    logic              miso_r;
    logic              new_r;
    logic              frm_r;

    // frame registers keep their values after deselect so the engine
    // can judge the frame; a deselect only arms a fresh start
    wire             frame_rst = spi.cs_n | ~nrst;
    wire [2:0]       bit_w     = new_r ? 3'h0 : bit_r;
    wire [CNT_W-1:0] byte_cw   = new_r ? '0 : byte_r;
    wire  [7:0]      byte_w    = {sh_r[6:0], spi.mosi};
    wire             byte_end  = (bit_w == LAST_BIT);
    wire             data_byte = byte_end & (byte_cw >= HDR_BYTES)
                                 & (op_r == OP_WRITE) & ~bsy_s2;

    always_ff @(posedge spi.sck or posedge frame_rst) begin
        if (frame_rst)
            new_r <= 1'b1;
        else if (spi.hold_n)
            new_r <= 1'b0;
    end

    always_ff @(posedge spi.sck or negedge nrst) begin
        if (!nrst) begin
            bit_r  <= '0;
            byte_r <= '0;
            sh_r   <= '0;
            op_r   <= '0;
            ahi_r  <= '0;
            alo_r  <= '0;
            idx_r  <= '0;
            mask_r <= '0;
            frm_r  <= 1'b0;
        end else if (spi.hold_n) begin
            sh_r  <= byte_w;
            bit_r <= bit_w + 3'h1;
            if (new_r) begin
                byte_r <= '0;
                mask_r <= '0;
                frm_r  <= ~frm_r;
            end
            if (byte_end) begin
                if (byte_cw != CNT_SAT)
                    byte_r <= byte_cw + ONE_BYTE;
                unique case (byte_cw)
                    6'h00: op_r <= byte_w;
                    6'h01: ahi_r <= byte_w;
                    6'h02: begin
                        alo_r <= byte_w;
                        idx_r <= byte_w[IDX_W-1:0];
                    end
                    default: begin
                        if (data_byte) begin
                            mask_r[idx_r] <= 1'b1;
                            idx_r <= idx_r + 5'h01;
                        end
                    end
                endcase
            end
        end
    end

    // page buffer; later bytes overwrite earlier ones at the same slot
    always_ff @(posedge spi.sck) begin
        if (~spi.cs_n && spi.hold_n && data_byte)
            pbuf[idx_r] <= byte_w;
    end

    // status crosses to the link clock through two flops
    always_ff @(posedge spi.sck or negedge nrst) begin
        if (!nrst) begin
            st_s1  <= '0;
            st_s2  <= '0;
            bsy_s1 <= 1'b0;
            bsy_s2 <= 1'b0;
        end else begin
            st_s1  <= so_r;
            st_s2  <= st_s1;
            bsy_s1 <= busy;
            bsy_s2 <= bsy_s1;
        end
    end

    // status read: bit 7 first after the opcode, repeating
    wire rdsr_on = ~new_r && (op_r == OP_RDSR) && (byte_r != '0);
    always_ff @(negedge spi.sck or posedge frame_rst) begin
        if (frame_rst)
            miso_r <= 1'b0;
        else if (spi.hold_n && rdsr_on)
            miso_r <= st_s2[LAST_BIT - bit_r];
    end

    assign spi.miso    = miso_r;
    assign spi.miso_oe = ~spi.cs_n & spi.hold_n & rdsr_on;

    // ==========================================================
    // engine side, clocked by mclk
    typedef enum logic [1:0] {SD_IDLE, SD_PROG, SD_SRWR} see_dst_e;
    see_dst_e          st_r;
    logic              cs_s1;
    logic              cs_s2;
    logic              cs_s3;
    logic              wp_s1;
    logic              wp_s2;
    logic              wel_r;
    logic [1:0]        bp_r;
    logic              srwp_r;
    logic [31:0]       tmr_r;
    logic [7:0]        mem [1 << ADDR_W];
    logic [7:0]        rd_r;
    logic              frm_q;
    logic [12:0]       tgt_q;
    logic [PAGE_BYTES-1:0] mask_q;
    logic [7:0]        sr_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
            wp_s1 <= 1'b0;
            wp_s2 <= 1'b0;
        end else begin
            cs_s1 <= spi.cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
            wp_s1 <= spi.wp_n;
            wp_s2 <= wp_s1;
        end
    end

    // link registers are quiet once cs_n is high, so read them here
    wire        cs_rise  = cs_s2 & ~cs_s3;
    // a frame with no sck edge leaves the old frame's state behind
    wire        fresh    = (frm_r != frm_q);
    wire        whole    = (bit_r == 3'h0) & fresh;
    wire [12:0] tgt      = {ahi_r[4:0], alo_r};
    wire        prot_hit = (bp_r == BP_ALL)
                         | ((bp_r == BP_HALF) & (tgt >= PROT_H_LO))
                         | ((bp_r == BP_QUARTER) & (tgt >= PROT_Q_LO));
    wire        go_set   = (op_r == OP_SET_LATCH) & (byte_r == ONE_BYTE);
    wire        go_clr   = (op_r == OP_CLR_LATCH) & (byte_r == ONE_BYTE);
    wire        go_prog  = (op_r == OP_WRITE) & wel_r & whole
                         & (byte_r >= MIN_WRITE) & ~prot_hit;
    wire        sr_lock  = srwp_r & ~wp_s2;
    wire        go_srwr  = (op_r == OP_STATUS_WR) & wel_r & whole
                         & (byte_r == STW_BYTES) & ~sr_lock;
    wire        tmr_done = (tmr_r == PROG_CNT - 1);
    wire [4:0]  cidx     = tmr_r[IDX_W-1:0];
    wire        commit   = (st_r == SD_PROG) && (tmr_r < PAGE_BYTES)
                           && mask_q[cidx];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r   <= SD_IDLE;
            wel_r  <= 1'b0;
            bp_r   <= '0;
            srwp_r <= 1'b0;
            tmr_r  <= '0;
            frm_q  <= 1'b0;
            tgt_q  <= '0;
            mask_q <= '0;
            sr_q   <= '0;
        end else begin
            if (cs_rise)
                frm_q <= frm_r;
            unique case (st_r)
                SD_IDLE: begin
                    tmr_r <= '0;
                    if (cs_rise && whole) begin
                        if (go_set)
                            wel_r <= 1'b1;
                        else if (go_clr)
                            wel_r <= 1'b0;
                        else if (go_prog) begin
                            // snapshot: the next frame may reuse the
                            // link registers while programming runs
                            st_r   <= SD_PROG;
                            tgt_q  <= tgt;
                            mask_q <= mask_r;
                        end else if (go_srwr) begin
                            st_r <= SD_SRWR;
                            sr_q <= ahi_r;
                        end
                    end
                end
                SD_PROG, SD_SRWR: begin
                    tmr_r <= tmr_r + 32'h1;
                    if (tmr_done) begin
                        if (st_r == SD_SRWR) begin
                            bp_r   <= {sr_q[ST_PROT_HI], sr_q[ST_PROT_LO]};
                            srwp_r <= sr_q[ST_SRWP];
                        end
                        wel_r <= 1'b0;
                        st_r  <= SD_IDLE;
                    end
                end
            endcase
        end
    end

    // the first page-size cycles of the program copy the buffer
    always_ff @(posedge mclk) begin
        if (commit)
            mem[{tgt_q[12:5], cidx}] <= pbuf[cidx];
        rd_r <= mem[rd_addr];
    end

    assign busy    = (st_r != SD_IDLE);
    assign wel     = wel_r;
    assign rd_data = rd_r;
    always_comb begin
        so_r          = '0;
        so_r[ST_BUSY] = busy;
        so_r[ST_WEL]  = wel_r;
        so_r[ST_PROT_LO] = bp_r[0];
        so_r[ST_PROT_HI] = bp_r[1];
        so_r[ST_SRWP] = srwp_r;
    end
endmodule

// ---- core/see_host.sv ----
// host end: builds frames, divides mclk into sck, drives pause
// assumes a user that offers one command at a time
`timescale 1ns/10ps
module see_host
    import see_pkg::*;
#(
    parameter int HALF   = SCK_HALF,
    parameter int PWRUP  = PWRUP_CYCLES
) (
    see_spi_if.host              spi,
    input  wire logic            mclk,
    input  wire logic            nrst,
    input  wire logic            cmd_valid,
    output logic                 cmd_ready,
    input  wire logic [7:0]      cmd_op,
    input  wire logic [15:0]     cmd_addr,
    input  wire logic [5:0]      cmd_len,
    input  wire logic [7:0]      data_in,
    output logic                 data_take,
    input  wire logic            pause_req,
    input  wire logic            wp_level,
    output logic      [7:0]      status_r,
    output logic                 done
);
    typedef enum logic [1:0] {SH_PWR, SH_IDLE, SH_SHIFT, SH_END}
        see_hst_e;
    see_hst_e    st_r;
    logic [15:0] cnt_r;
    logic [7:0]  op_r;
    logic [15:0] addr_r;
    logic [5:0]  tot_r;
    logic [5:0]  byte_r;
    logic [2:0]  bit_r;
    logic [7:0]  tx_r;
    logic [7:0]  rx_r;
    logic        sck_r;
    logic        cs_r;
    logic        hold_r;
    logic        mi_s1;
    logic        mi_s2;

    wire       half_end = (cnt_r == 16'(HALF - 1));
    wire [5:0] nxt_byte = byte_r + ONE_BYTE;
    wire       nxt_data = (nxt_byte >= HDR_BYTES) |
                          ((op_r == OP_STATUS_WR) & (nxt_byte == ONE_BYTE));
    wire [7:0] nxt_tx   = (nxt_byte == ONE_BYTE && op_r != OP_STATUS_WR) ?
                          addr_r[15:8] :
                          (nxt_byte == STW_BYTES) ? addr_r[7:0] :
                          data_in;
    wire [5:0] len_w    = (cmd_op == OP_WRITE) ? HDR_BYTES + cmd_len :
                          (cmd_op == OP_STATUS_WR || cmd_op == OP_RDSR) ?
                          STW_BYTES : ONE_BYTE;

    assign cmd_ready  = (st_r == SH_IDLE);
    assign data_take  = (st_r == SH_SHIFT) & sck_r & half_end
                        & (bit_r == LAST_BIT) & (nxt_byte != tot_r)
                        & nxt_data;
    assign spi.cs_n   = cs_r;
    assign spi.sck    = sck_r;
    assign spi.mosi   = tx_r[7];
    assign spi.hold_n = hold_r;
    assign spi.wp_n   = wp_level;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mi_s1 <= 1'b0;
            mi_s2 <= 1'b0;
        end else begin
            mi_s1 <= spi.miso;
            mi_s2 <= mi_s1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r     <= SH_PWR;
            cnt_r    <= '0;
            op_r     <= '0;
            addr_r   <= '0;
            tot_r    <= '0;
            byte_r   <= '0;
            bit_r    <= '0;
            tx_r     <= '0;
            rx_r     <= '0;
            sck_r    <= 1'b0;
            cs_r     <= 1'b1;
            hold_r   <= 1'b1;
            status_r <= '0;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (st_r)
                SH_PWR: begin
                    cnt_r <= cnt_r + 16'h1;
                    if (cnt_r == 16'(PWRUP - 1)) begin
                        st_r  <= SH_IDLE;
                        cnt_r <= '0;
                    end
                end
                SH_IDLE: begin
                    cnt_r <= '0;
                    if (cmd_valid) begin
                        op_r   <= cmd_op;
                        addr_r <= cmd_addr;
                        tot_r  <= len_w;
                        tx_r   <= cmd_op;
                        byte_r <= '0;
                        bit_r  <= '0;
                        cs_r   <= 1'b0;
                        st_r   <= SH_SHIFT;
                    end
                end
                SH_SHIFT: begin
                    if (!sck_r)
                        hold_r <= ~pause_req;
                    if (!half_end)
                        cnt_r <= cnt_r + 16'h1;
                    else if (!sck_r) begin
                        if (hold_r && !pause_req) begin
                            cnt_r <= '0;
                            sck_r <= 1'b1;
                            rx_r  <= {rx_r[6:0], mi_s2};
                        end
                    end else begin
                        cnt_r <= '0;
                        sck_r <= 1'b0;
                        bit_r <= bit_r + 3'h1;
                        if (bit_r != LAST_BIT)
                            tx_r <= {tx_r[6:0], 1'b0};
                        else begin
                            byte_r <= nxt_byte;
                            tx_r   <= nxt_tx;
                            if (nxt_byte == tot_r)
                                st_r <= SH_END;
                        end
                    end
                end
                SH_END: begin
                    cnt_r <= cnt_r + 16'h1;
                    if (cnt_r == 16'(2 * HALF - 1)) begin
                        cnt_r <= '0;
                        st_r  <= SH_IDLE;
                        done  <= 1'b1;
                        if (op_r == OP_RDSR)
                            status_r <= rx_r;
                    end else if (half_end)
                        cs_r <= 1'b1;
                end
            endcase
        end
    end
endmodule

// ---- verification/see_link_properties.sv ----
// checker on the link wires between the two ends
// assumes sampling on mclk with the host making sck from mclk
`timescale 1ns/10ps
module see_link_properties #(
    parameter int HALF = 20
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic miso,
    input wire logic miso_oe
);
    // ==========================================================
    // helper counters: high time of sck, sck rises in a frame
    logic       sck_q;
    logic [9:0] hi_cnt_r;
    logic [9:0] rise_cnt_r;
    wire        sck_rise = sck && !sck_q;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sck_q      <= 1'b0;
            hi_cnt_r   <= 10'h000;
            rise_cnt_r <= 10'h000;
        end else begin
            sck_q      <= sck;
            hi_cnt_r   <= sck ? hi_cnt_r + 10'h001 : 10'h000;
            rise_cnt_r <= cs_n ? 10'h000 : rise_cnt_r + 10'(sck_rise);
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);

    // ==========================================================
    // assertions
    property p_pause_floats; !hold_n |-> !miso_oe; endproperty
    a_pause_floats: assert property (p_pause_floats)
        else $error("output driven while paused");
    property p_desel_floats; cs_n |-> !miso_oe; endproperty
    a_desel_floats: assert property (p_desel_floats)
        else $error("output driven while deselected");
    property p_pause_sck_low;
        $changed(hold_n) |-> !sck && !$past(sck);
    endproperty
    a_pause_sck_low: assert property (p_pause_sck_low)
        else $error("pause pin moved with sck high");
    property p_pause_enter; $fell(hold_n) |-> !cs_n ##1 !sck; endproperty
    a_pause_enter: assert property (p_pause_enter)
        else $error("pause taken outside a frame");
    property p_sck_idle; cs_n |-> !sck; endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("sck not idle low between frames");
    property p_mosi_hold; sck && $past(sck) |-> $stable(mosi); endproperty
    a_mosi_hold: assert property (p_mosi_hold)
        else $error("mosi moved while sck high");
    property p_sck_high_time;
        $fell(sck) && !cs_n |-> hi_cnt_r == 10'(HALF);
    endproperty
    a_sck_high_time: assert property (p_sck_high_time)
        else $error("sck high time wrong");
    property p_cs_on_byte;
        $rose(cs_n) |-> rise_cnt_r[2:0] == 3'h0 && rise_cnt_r != 10'h000;
    endproperty
    a_cs_on_byte: assert property (p_cs_on_byte)
        else $error("deselect off a byte boundary");
    property p_cs_gap; $rose(cs_n) |-> cs_n [*4]; endproperty
    a_cs_gap: assert property (p_cs_gap)
        else $error("deselect too short");
    property p_out_after_op; $rose(miso_oe) |-> rise_cnt_r >= 10'h007;
    endproperty
    a_out_after_op: assert property (p_out_after_op)
        else $error("output enabled before opcode done");
endmodule

// ---- verification/spi_eeprom_write_hold_ctrl_tb.sv ----
// self-checking bench: host end facing eeprom end, plus a second
// eeprom end fed by a bench bit driver that breaks framing on purpose
`timescale 1ns/10ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    fails++; $display("Error t=%0t got %0h exp %0h", $time, a, e); end end
module spi_eeprom_write_hold_ctrl_tb;
    import see_pkg::*;
    localparam int HALF = 10;
    localparam int PROG = 2000;
    logic        mclk = 1'b0;
    logic        nrst = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        pause_req = 1'b0;
    logic        wp_level = 1'b1;
    logic [7:0]  cmd_op = 8'h00;
    logic [15:0] cmd_addr = 16'h0000;
    logic [5:0]  cmd_len = 6'h00;
    logic [12:0] rd_addr = 13'h0000;
    logic [7:0]  wbuf [64];
    logic [5:0]  widx = 6'h00;
    logic [7:0]  rd_data, status_r, rd_data_b;
    logic        cmd_ready, data_take, done, busy, wel, busy_b, wel_b;
    int          fails = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    wire  [7:0]  data_in = wbuf[widx];

    see_spi_if spi ();
    see_spi_if spi_b ();
    see_host #(.HALF(HALF), .PWRUP(10)) i_see_host (.spi(spi),
        .mclk(mclk), .nrst(nrst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_len(cmd_len), .data_in(data_in), .data_take(data_take),
        .pause_req(pause_req), .wp_level(wp_level),
        .status_r(status_r), .done(done));
    see_dev #(.PROG_CNT(PROG)) i_see_dev (.spi(spi), .mclk(mclk),
        .nrst(nrst), .rd_addr(rd_addr), .rd_data(rd_data),
        .busy(busy), .wel(wel));
    see_dev #(.PROG_CNT(PROG)) i_see_dev_flt (.spi(spi_b), .mclk(mclk),
        .nrst(nrst), .rd_addr(rd_addr), .rd_data(rd_data_b),
        .busy(busy_b), .wel(wel_b));
    see_link_properties #(.HALF(HALF)) i_see_link_properties (
        .mclk(mclk), .nrst(nrst), .cs_n(spi.cs_n), .sck(spi.sck),
        .mosi(spi.mosi), .hold_n(spi.hold_n), .wp_n(spi.wp_n),
        .miso(spi.miso), .miso_oe(spi.miso_oe));

    initial begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (data_take === 1'b1)
            widx <= widx + 6'h01;
        cyc++;
        if (cyc == 60000) begin
            fails++;
            print_verdict();
        end
    end

    // ==========================================================
    // tasks
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic run(input logic [7:0] op, input logic [15:0] a,
                       input logic [5:0] len);
        @(posedge mclk);
        cmd_op <= op;
        cmd_addr <= a;
        cmd_len <= len;
        widx <= 6'h00;
        cmd_valid <= 1'b1;
        do @(negedge mclk); while (cmd_ready !== 1'b1);
        @(posedge mclk);
        cmd_valid <= 1'b0;
        do @(negedge mclk); while (done !== 1'b1);
        repeat (8) @(negedge mclk);
    endtask
    task automatic prog_wait();
        int n;
        n = 0;
        `CHK(busy, 1'b1)
        while (busy === 1'b1 && n < PROG + 100) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n <= PROG, 1'b1)
        `CHK(wel, 1'b0)
    endtask
    task automatic peek(input logic [12:0] a, input logic [7:0] e);
        @(posedge mclk);
        rd_addr <= a;
        @(posedge mclk);
        @(negedge mclk);
        `CHK(rd_data, e)
    endtask
    // bit driver on the second link, msb first, 48 ns sck
    task automatic bb(input logic [39:0] v, input int n);
        spi_b.cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_b.mosi = v[39-i];
            #24 spi_b.sck = 1'b1;
            #24 spi_b.sck = 1'b0;
        end
        #24 spi_b.cs_n = 1'b1;
        spi_b.mosi = ~spi_b.mosi;
        #100;
    endtask

    // ==========================================================
    // tests
    initial begin
        spi_b.cs_n = 1'b1;
        spi_b.sck = 1'b0;
        spi_b.mosi = 1'b0;
        spi_b.hold_n = 1'b1;
        spi_b.wp_n = 1'b1;
        for (int k = 0; k < 64; k++)
            wbuf[k] = 8'h10 + 8'(k);
        repeat (5) @(posedge mclk);
        nrst <= 1'b1;
        @(negedge mclk);
        `CHK(wel, 1'b0)
        run(OP_WRITE, 16'h0100, 6'h01);
        `CHK(busy, 1'b0)
        $display("test locked write done");
        run(OP_SET_LATCH, 16'h0000, 6'h00);
        `CHK(wel, 1'b1)
        run(OP_CLR_LATCH, 16'h0000, 6'h00);
        `CHK(wel, 1'b0)
        $display("test latch done");
        run(OP_SET_LATCH, 16'h0000, 6'h00);
        run(OP_WRITE, 16'hE3FC, 6'h08);
        run(OP_RDSR, 16'h0000, 6'h00);
        `CHK(status_r[0], 1'b1)
        prog_wait();
        for (int k = 0; k < 8; k++)
            peek(13'h03E0 + 13'((28 + k) % 32), 8'h10 + 8'(k));
        $display("test page wrap done");
        run(OP_SET_LATCH, 16'h0000, 6'h00);
        run(OP_WRITE, 16'h0040, 6'h28);
        prog_wait();
        for (int s = 0; s < 32; s++)
            peek(13'h0040 + 13'(s), 8'h10 + 8'(s < 8 ? s + 32 : s));
        $display("test overflow done");
        wbuf[0] = 8'h04;
        run(OP_SET_LATCH, 16'h0000, 6'h00);
        run(OP_STATUS_WR, 16'h0000, 6'h01);
        prog_wait();
        run(OP_RDSR, 16'h0000, 6'h00);
        `CHK(status_r[3:2], BP_QUARTER)
        run(OP_SET_LATCH, 16'h0000, 6'h00);
        run(OP_WRITE, 16'h1800, 6'h01);
        `CHK(busy, 1'b0)
        `CHK(wel, 1'b1)
        wbuf[0] = 8'h00;
        run(OP_STATUS_WR, 16'h0000, 6'h01);
        prog_wait();
        $display("test protect done");
        wbuf[0] = 8'h10;
        run(OP_SET_LATCH, 16'h0000, 6'h00);
        fork
            run(OP_WRITE, 16'h0200, 6'h04);
            begin
                repeat (300) @(posedge mclk);
                pause_req <= 1'b1;
                repeat (400) @(posedge mclk);
                pause_req <= 1'b0;
            end
        join
        prog_wait();
        for (int k = 0; k < 4; k++)
            peek(13'h0200 + 13'(k), 8'h10 + 8'(k));
        $display("test pause done");
        bb({OP_SET_LATCH, 32'h0}, 8);
        `CHK(wel_b, 1'b1)
        bb({OP_WRITE, 16'h0000, 8'h55, 8'h00}, 35);
        `CHK(busy_b, 1'b0)
        `CHK(wel_b, 1'b1)
        bb({OP_STATUS_WR, 8'h04, 8'h00, 16'h0}, 24);
        `CHK(busy_b, 1'b0)
        bb({OP_STATUS_WR, 8'h04, 24'h0}, 16);
        `CHK(busy_b, 1'b1)
        $display("test framing faults done");
        print_verdict();
    end
endmodule
